/* hw/pps_cfg_regs.sv */
// Clock configuration register (second) and deep-sleep voltage register,
// an AHB-Lite slave with its pre-divider clock paths.
// Assumes a single AHB-Lite master; hready comes back from hreadyout.
// The companion configuration register sits outside and shares one bit.

module pps_cfg_regs
  import pps_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Companion register view
  input  wire logic [2:0]    adc_psc_low_bits,
  input  wire logic          companion_bit_write,
  input  wire logic          companion_bit_wdata,
  output logic               shared_prediv_bit,
  // Clock source ticks and derived ticks
  input  wire pps_src_tick_t src_tick,
  input  wire logic          second_prediv_in_tick,
  output logic               main_pll_ref_tick,
  output logic               first_prediv_tick,
  output logic               second_prediv_tick,
  // Decoded configuration
  output pps_clk_cfg_t       clk_cfg
);

  // ******************************************************************
  // Multiplier code decode
  // ******************************************************************
  function automatic logic [5:0] mf_decode(input logic [3:0] code);
    logic [5:0] res;
    res = 6'h01;
    case (code)
      4'h6:    res = 6'h10;
      4'h7:    res = 6'h12;
      4'h8:    res = 6'h14;
      4'h9:    res = 6'h16;
      4'ha:    res = 6'h18;
      4'hb:    res = 6'h1a;
      4'hc:    res = 6'h1c;
      4'he:    res = 6'h20;
      4'hf:    res = 6'h28;
      default: res = 6'h01;
    endcase
    return res;
  endfunction : mf_decode

  // ******************************************************************
  // Declarations
  // ******************************************************************
  pps_bus_state_t state_reg;
  pps_bus_state_t state_next;
  logic [7:0]     addr_reg;
  logic [1:0]     size_reg;
  logic [31:0]    cfg_reg;
  logic [31:0]    cfg_next;
  logic [31:0]    dsv_reg;
  logic [31:0]    dsv_next;
  logic [31:0]    hrdata_reg;
  logic [31:0]    hrdata_next;
  logic           take;
  logic           take_wr;
  logic           take_rd;
  logic           data_wr;
  logic [3:0]     lanes;
  logic [31:0]    lane_mask;
  logic           hit_cfg;
  logic           hit_dsv;
  logic [31:0]    cfg_wmask;
  logic [31:0]    dsv_wmask;
  logic           bus_hits_bit0;
  logic [31:0]    read_value;
  logic [5:0]     third_mf;
  logic [5:0]     second_mf;
  logic           first_prediv_in;
  logic [10:0]    millivolts;

  // ******************************************************************
  // Address phase
  // ******************************************************************
  // A transfer is taken on a valid NONSEQ/SEQ with hready high
  assign take    = hsel && htrans[1] && hready;
  assign take_wr = take && hwrite;
  assign take_rd = take && !hwrite;

  // Bus slave sequencing: writes take no wait, reads one wait state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PPS_BUS_RD_WAIT: begin
        state_next = PPS_BUS_RD_DONE;
      end
      PPS_BUS_IDLE,
      PPS_BUS_WRITE,
      PPS_BUS_RD_DONE: begin
        if (take_wr) begin
          state_next = PPS_BUS_WRITE;
        end else if (take_rd) begin
          state_next = PPS_BUS_RD_WAIT;
        end else begin
          state_next = PPS_BUS_IDLE;
        end
      end
      default: begin
        state_next = PPS_BUS_IDLE;
      end
    endcase
  end

  // State and captured address phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= PPS_BUS_IDLE;
      addr_reg  <= 8'h00;
      size_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        addr_reg <= haddr[7:0];
        size_reg <= hsize[1:0];
      end
    end
  end

  // ******************************************************************
  // Data phase decode
  // ******************************************************************
  assign data_wr = (state_reg == PPS_BUS_WRITE);

  // Only the two documented word offsets decode
  assign hit_cfg =
      (addr_reg[7:2] == PPS_OFS_CLOCK_CONFIG_SECOND[7:2]);
  assign hit_dsv =
      (addr_reg[7:2] == PPS_OFS_DEEP_SLEEP_VOLTAGE[7:2]);

  // Byte lanes from transfer size and low address bits
  assign lanes =
      (size_reg == PPS_HSIZE_BYTE[1:0]) ? (4'h1 << addr_reg[1:0])
    : (size_reg == PPS_HSIZE_HALF[1:0]) ? (addr_reg[1] ? 4'hc : 4'h3)
    : 4'hf;

  // Expand lanes to a bit mask, one byte per lane
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{lanes[g]}};
    end
  endgenerate

  // Reserved positions never take written values
  assign cfg_wmask = (data_wr && hit_cfg)
                   ? (lane_mask & PPS_WMASK_CLOCK_CONFIG)
                   : 32'h0000_0000;
  assign dsv_wmask = (data_wr && hit_dsv)
                   ? (lane_mask & PPS_WMASK_SLEEP_VOLTAGE)
                   : 32'h0000_0000;

  assign bus_hits_bit0 = cfg_wmask[PPS_POS_FIRST_PDIV];

  // ******************************************************************
  // Register update
  // ******************************************************************
  // Merge written lanes; companion write reaches the shared bit unless a bus write hits bit 0 in the same cycle
  always_comb begin
    cfg_next = (cfg_reg & ~cfg_wmask) | (hwdata & cfg_wmask);
    if (companion_bit_write && !bus_hits_bit0) begin
      cfg_next[PPS_POS_FIRST_PDIV] = companion_bit_wdata;
    end
    dsv_next = (dsv_reg & ~dsv_wmask) | (hwdata & dsv_wmask);
  end

  // Storage, cleared by system reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= PPS_RST_CLOCK_CONFIG_SECOND;
      dsv_reg <= PPS_RST_DEEP_SLEEP_VOLTAGE;
    end else begin
      cfg_reg <= cfg_next;
      dsv_reg <= dsv_next;
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  // Unmapped offsets read zero
  assign read_value =
      hit_cfg ? (cfg_reg & PPS_WMASK_CLOCK_CONFIG)
    : hit_dsv ? (dsv_reg & PPS_WMASK_SLEEP_VOLTAGE)
    : 32'h0000_0000;

  assign hrdata_next = (state_reg == PPS_BUS_RD_WAIT) ? read_value
                                                      : hrdata_reg;

  // Read data held until the next read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = (state_reg != PPS_BUS_RD_WAIT);
  assign hresp     = PPS_HRESP_OKAY;

  // ******************************************************************
  // Clock source paths
  // ******************************************************************
  // Main PLL reference: crystal when clear, 48 MHz RC when set
  assign main_pll_ref_tick = cfg_reg[PPS_POS_MAIN_PLL_REF]
                           ? src_tick.internal_rc_48m_clock
                           : src_tick.external_fast_crystal;

  // First pre-divider input: reference or second PLL
  assign first_prediv_in = cfg_reg[PPS_POS_FIRST_PDIV_INSEL]
                         ? src_tick.second_pll_output
                         : main_pll_ref_tick;

  // First pre-divider, divide by field plus one
  pps_predivider u_first_prediv (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .in_tick  (first_prediv_in),
    .ratio    (cfg_reg[PPS_POS_FIRST_PDIV +: 4]),
    .out_tick (first_prediv_tick)
  );

  // Second pre-divider, divide by field plus one
  pps_predivider u_second_prediv (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .in_tick  (second_prediv_in_tick),
    .ratio    (cfg_reg[PPS_POS_SECOND_PDIV +: 4]),
    .out_tick (second_prediv_tick)
  );

  // ******************************************************************
  // Decoded configuration
  // ******************************************************************
  assign third_mf  = mf_decode(cfg_reg[PPS_POS_THIRD_PLL_MF +: 4]);
  assign second_mf = mf_decode(cfg_reg[PPS_POS_SECOND_PLL_MF +: 4]);

  // Deep-sleep voltage code to millivolts
  assign millivolts =
      (dsv_reg[1:0] == 2'h0) ? PPS_MV_CODE0
    : (dsv_reg[1:0] == 2'h1) ? PPS_MV_CODE1
    : (dsv_reg[1:0] == 2'h2) ? PPS_MV_CODE2
    : PPS_MV_CODE3;

  // Field view for the clock tree and power controller
  assign clk_cfg.main_pll_ref_select = cfg_reg[PPS_POS_MAIN_PLL_REF];
  assign clk_cfg.adc_clock_prescaler =
      {cfg_reg[PPS_POS_ADC_PSC_MSB], adc_psc_low_bits};
  assign clk_cfg.second_audio_clock_select =
      cfg_reg[PPS_POS_SECOND_AUDIO];
  assign clk_cfg.first_audio_clock_select =
      cfg_reg[PPS_POS_FIRST_AUDIO];
  assign clk_cfg.first_prediv_input_select =
      cfg_reg[PPS_POS_FIRST_PDIV_INSEL];
  assign clk_cfg.third_pll_multiplier = cfg_reg[PPS_POS_THIRD_PLL_MF +: 4];
  assign clk_cfg.third_pll_factor         = third_mf[5:1];
  assign clk_cfg.third_pll_code_reserved  = third_mf[0];
  assign clk_cfg.second_pll_multiplier =
      cfg_reg[PPS_POS_SECOND_PLL_MF +: 4];
  assign clk_cfg.second_pll_factor        = second_mf[5:1];
  assign clk_cfg.second_pll_code_reserved = second_mf[0];
  assign clk_cfg.second_predivider = cfg_reg[PPS_POS_SECOND_PDIV +: 4];
  assign clk_cfg.first_predivider  = cfg_reg[PPS_POS_FIRST_PDIV +: 4];
  assign clk_cfg.sleep_core_voltage_code =
      dsv_reg[PPS_POS_SLEEP_VOLT +: 2];
  assign clk_cfg.sleep_core_millivolts = millivolts;

  // Shared storage bit seen by the companion register
  assign shared_prediv_bit = cfg_reg[PPS_POS_FIRST_PDIV];

endmodule : pps_cfg_regs

/* hw/pps_pkg.sv */
// Constants, field layout and carrier types of the PLL pre-divider and
// deep-sleep voltage configuration block.
// Assumes one 200 MHz system clock and an AHB-Lite register bus.
//
// Function
// - Bit 30 picks the main PLL reference: crystal at 0, 48 MHz RC at 1.
// - Bit 29 is the ADC prescaler top bit; low bits sit elsewhere.
// - Bit 18 picks second audio clock: system at 0, 2x third PLL at 1.
// - Bit 17 picks first audio clock: system at 0, 2x third PLL at 1.
// - Bit 16 feeds first pre-divider: reference at 0, second PLL at 1.
// - Bits 15:12 give third PLL factor 8..14, 16 or 20; others reserved.
// - Bits 11:8 set the second PLL factor with the same code table.
// - Bits 7:4 divide the second pre-divider input by value plus one.
// - Bits 3:0 divide the first pre-divider input by value plus one.
// - First pre-divider bit 0 is one flop shared with companion bit 17.
// - Voltage code 00/01/10/11 asks for 1.0/0.9/0.8/1.2 V in deep-sleep.
// - Both registers reset to all zeros.
// - The voltage register takes byte, half and word writes per lane.

package pps_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [7:0]  PPS_OFS_CLOCK_CONFIG_SECOND = 8'h2c;
  localparam logic [7:0]  PPS_OFS_DEEP_SLEEP_VOLTAGE  = 8'h34;
  localparam logic [31:0] PPS_RST_CLOCK_CONFIG_SECOND = 32'h0000_0000;
  localparam logic [31:0] PPS_RST_DEEP_SLEEP_VOLTAGE  = 32'h0000_0000;
  localparam logic [31:0] PPS_WMASK_CLOCK_CONFIG      = 32'h6007_ffff;
  localparam logic [31:0] PPS_WMASK_SLEEP_VOLTAGE     = 32'h0000_0003;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int PPS_POS_MAIN_PLL_REF     = 30;
  localparam int PPS_POS_ADC_PSC_MSB      = 29;
  localparam int PPS_POS_SECOND_AUDIO     = 18;
  localparam int PPS_POS_FIRST_AUDIO      = 17;
  localparam int PPS_POS_FIRST_PDIV_INSEL = 16;
  localparam int PPS_POS_THIRD_PLL_MF     = 12;
  localparam int PPS_POS_SECOND_PLL_MF    = 8;
  localparam int PPS_POS_SECOND_PDIV      = 4;
  localparam int PPS_POS_FIRST_PDIV       = 0;
  localparam int PPS_POS_SLEEP_VOLT       = 0;

  // ******************************************************************
  // Deep-sleep voltage in millivolts per code
  // ******************************************************************
  localparam logic [10:0] PPS_MV_CODE0 = 11'h3e8;
  localparam logic [10:0] PPS_MV_CODE1 = 11'h384;
  localparam logic [10:0] PPS_MV_CODE2 = 11'h320;
  localparam logic [10:0] PPS_MV_CODE3 = 11'h4b0;

  // ******************************************************************
  // AHB-Lite encodings
  // ******************************************************************
  localparam logic [2:0] PPS_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] PPS_HSIZE_HALF = 3'h1;
  localparam logic       PPS_HRESP_OKAY = 1'h0;

  // Bus slave states
  typedef enum logic [1:0] {
    PPS_BUS_IDLE    = 2'b00,
    PPS_BUS_WRITE   = 2'b01,
    PPS_BUS_RD_WAIT = 2'b10,
    PPS_BUS_RD_DONE = 2'b11
  } pps_bus_state_t;

  // Configuration presented to the clock tree
  typedef struct packed {
    logic        main_pll_ref_select;
    logic [3:0]  adc_clock_prescaler;
    logic        second_audio_clock_select;
    logic        first_audio_clock_select;
    logic        first_prediv_input_select;
    logic [3:0]  third_pll_multiplier;
    logic [4:0]  third_pll_factor;
    logic        third_pll_code_reserved;
    logic [3:0]  second_pll_multiplier;
    logic [4:0]  second_pll_factor;
    logic        second_pll_code_reserved;
    logic [3:0]  second_predivider;
    logic [3:0]  first_predivider;
    logic [1:0]  sleep_core_voltage_code;
    logic [10:0] sleep_core_millivolts;
  } pps_clk_cfg_t;

  // Clock source ticks, one-cycle strobes in the system clock domain
  typedef struct packed {
    logic external_fast_crystal;
    logic internal_rc_48m_clock;
    logic second_pll_output;
  } pps_src_tick_t;

endpackage : pps_pkg

/* hw/pps_predivider.sv */
// Divide-by-(ratio+1) tick divider for the pre-divider stages.
// Assumes the input tick is a one-cycle strobe in the clk_sys domain.

module pps_predivider
  import pps_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       in_tick,
  input  wire logic [3:0] ratio,
  output logic            out_tick
);

  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic       wrap;
  logic       out_tick_reg;

  // ******************************************************************
  // Count input ticks, emit one per ratio+1 of them
  // ******************************************************************
  assign wrap       = in_tick && (count_reg >= ratio);
  assign count_next = wrap ? 4'h0
                    : (in_tick ? count_reg + 4'h1 : count_reg);

  // Counter and registered output strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg    <= 4'h0;
      out_tick_reg <= 1'b0;
    end else begin
      count_reg    <= count_next;
      out_tick_reg <= wrap;
    end
  end

  assign out_tick = out_tick_reg;

endmodule : pps_predivider

/* verification/pps_cfg_regs_sva.sv */
// Concurrent checks on the configuration register block ports.
// Assumes one clock clk_sys and the asynchronous active-high reset rst.
module pps_cfg_regs_sva
  import pps_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [2:0]    hsize,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [2:0]    adc_psc_low_bits,
  input wire logic          companion_bit_write,
  input wire logic          companion_bit_wdata,
  input wire logic          shared_prediv_bit,
  input wire pps_src_tick_t src_tick,
  input wire logic          second_prediv_in_tick,
  input wire logic          main_pll_ref_tick,
  input wire logic          first_prediv_tick,
  input wire logic          second_prediv_tick,
  input wire pps_clk_cfg_t  clk_cfg
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Short names for decoded fields
  wire logic [3:0] m2 = clk_cfg.second_pll_multiplier;
  wire logic [3:0] m3 = clk_cfg.third_pll_multiplier;
  wire logic [1:0] vc = clk_cfg.sleep_core_voltage_code;

  property p_ref_mux;
    main_pll_ref_tick == (clk_cfg.main_pll_ref_select ?
      src_tick.internal_rc_48m_clock : src_tick.external_fast_crystal);
  endproperty
  a_ref_mux: assert property (p_ref_mux)
    else $error("reference tick mux wrong");
  property p_adc;
    clk_cfg.adc_clock_prescaler[2:0] == adc_psc_low_bits;
  endproperty
  a_adc: assert property (p_adc)
    else $error("prescaler low bits wrong");
  property p_shared;
    shared_prediv_bit == clk_cfg.first_predivider[0];
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared bit views differ");
  property p_comp;
    companion_bit_write && !hsel && !$past(hsel)
      |=> shared_prediv_bit == $past(companion_bit_wdata);
  endproperty
  a_comp: assert property (p_comp)
    else $error("companion write lost");
  property p_mf3;
    clk_cfg.third_pll_code_reserved == (m3 < 4'h6 || m3 == 4'hd);
  endproperty
  a_mf3: assert property (p_mf3)
    else $error("third multiplier reserved flag wrong");
  property p_mf2;
    clk_cfg.second_pll_factor == (m2 == 4'hf ? 5'h14 : m2 == 4'he ? 5'h10 :
      (m2 < 4'h6 || m2 == 4'hd) ? 5'h00 : {1'b0, m2 + 4'h2});
  endproperty
  a_mf2: assert property (p_mf2)
    else $error("second multiplier factor wrong");
  property p_mv;
    clk_cfg.sleep_core_millivolts == (vc == 2'h0 ? 11'h3e8 :
      vc == 2'h1 ? 11'h384 : vc == 2'h2 ? 11'h320 : 11'h4b0);
  endproperty
  a_mv: assert property (p_mv)
    else $error("sleep voltage decode wrong");
  property p_rd;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read wait state wrong");
  property p_pdiv;
    first_prediv_tick && clk_cfg.first_predivider != 4'h0 &&
      $stable(clk_cfg.first_predivider) |=> !first_prediv_tick;
  endproperty
  a_pdiv: assert property (p_pdiv)
    else $error("divided tick too dense");
endmodule : pps_cfg_regs_sva

bind pps_cfg_regs pps_cfg_regs_sva u_sva (.clk_sys, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .adc_psc_low_bits, .companion_bit_write, .companion_bit_wdata,
  .shared_prediv_bit, .src_tick, .second_prediv_in_tick, .main_pll_ref_tick,
  .first_prediv_tick, .second_prediv_tick, .clk_cfg);

/* verification/pps_cfg_regs_test.sv */
// Self-checking bench for the configuration register block.
// Assumes the bench is the only AHB-Lite master; hready is hreadyout.
module pps_cfg_regs_test
  import pps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize, adc_psc_low_bits;
  logic          companion_bit_write, companion_bit_wdata, shared_prediv_bit;
  logic          second_prediv_in_tick, main_pll_ref_tick;
  logic          first_prediv_tick, second_prediv_tick;
  pps_src_tick_t src_tick;
  pps_clk_cfg_t  clk_cfg;
  int            failures, n_tests, cyc, n1, n2;
  wire logic [3:0] sels = {clk_cfg.main_pll_ref_select,
    clk_cfg.second_audio_clock_select, clk_cfg.first_audio_clock_select,
    clk_cfg.first_prediv_input_select};

  assign hready = hreadyout;
  pps_cfg_regs dut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .adc_psc_low_bits,
    .companion_bit_write, .companion_bit_wdata, .shared_prediv_bit,
    .src_tick, .second_prediv_in_tick, .main_pll_ref_tick,
    .first_prediv_tick, .second_prediv_tick, .clk_cfg);

  // ****************************************************************
  // Clock, tick counters and timeout
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n1 <= n1 + first_prediv_tick;
    n2 <= n2 + second_prediv_tick;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits for hready at a rising edge, taking read data there
  task automatic wt(output logic [31:0] d);
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : wt
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] s,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    wt(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt(rd);
  endtask : bus
  task automatic wr(input logic [31:0] a, d, input logic [2:0] s = 3'h2);
    logic [31:0] x;
    bus(1'b1, a, s, d, x);
    // Written value lands at the data-phase edge; look one edge later
    @(posedge clk_sys);
  endtask : wr
  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] d;
    bus(1'b0, a, 3'h2, 32'h0, d);
    chk(d, e);
  endtask : rdc

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fields();
    int bl[4] = '{30, 18, 17, 16};
    rdc(32'h2c, 32'h0);
    rdc(32'h34, 32'h0);
    wr(32'h2c, 32'hffff_ffff);
    rdc(32'h2c, 32'h6007_ffff);
    chk(clk_cfg.adc_clock_prescaler, 32'hd);
    chk(clk_cfg.second_predivider, 32'hf);
    chk(clk_cfg.first_predivider, 32'hf);
    foreach (bl[i]) begin
      wr(32'h2c, 32'h1 << bl[i]);
      chk(sels, 32'h8 >> i);
    end
    wr(32'h2c, 32'h0);
    wr(32'h2e, 32'hffff_ffff, PPS_HSIZE_BYTE);
    rdc(32'h2c, 32'h0007_0000);
  endtask : t_fields
  task automatic t_mult();
    logic [31:0] f;
    for (int c = 0; c < 16; c++) begin
      f = (c == 15) ? 20 : (c == 14) ? 16 : (c > 5 && c < 13) ? c + 2 : 0;
      wr(32'h2c, c * 32'h1100);
      chk(clk_cfg.third_pll_multiplier, c);
      chk(clk_cfg.second_pll_multiplier, c);
      chk(clk_cfg.third_pll_factor, f);
      chk(clk_cfg.third_pll_code_reserved, f == 0);
      chk(clk_cfg.second_pll_factor, f);
      chk(clk_cfg.second_pll_code_reserved, f == 0);
    end
  endtask : t_mult
  task automatic t_dsv();
    logic [31:0] mv[4] = '{32'h3e8, 32'h384, 32'h320, 32'h4b0};
    for (int c = 0; c < 4; c++) begin
      wr(32'h34, 32'hffff_fffc | c);
      rdc(32'h34, c);
      chk(clk_cfg.sleep_core_millivolts, mv[c]);
      chk(clk_cfg.sleep_core_voltage_code, c);
    end
    wr(32'h34, 32'hffff_ff01, PPS_HSIZE_BYTE);
    wr(32'h35, 32'h0, PPS_HSIZE_BYTE);
    wr(32'h36, 32'h0, PPS_HSIZE_HALF);
    rdc(32'h34, 32'h1);
    wr(32'h30, 32'hffff_ffff);
    rdc(32'h30, 32'h0);
    chk(hresp, PPS_HRESP_OKAY);
  endtask : t_dsv
  task automatic t_comp();
    wr(32'h2c, 32'h0);
    companion_bit_wdata <= 1'b1;
    companion_bit_write <= 1'b1;
    @(posedge clk_sys);
    companion_bit_write <= 1'b0;
    @(posedge clk_sys);
    chk(shared_prediv_bit, 32'h1);
    rdc(32'h2c, 32'h1);
    wr(32'h2c, 32'h2);
    chk(shared_prediv_bit, 32'h0);
  endtask : t_comp
  // Source sel: 0 crystal, 1 RC via bit 30, 2 second PLL via bit 16
  task automatic t_div(input int sel, input logic [3:0] r);
    int b1, b2;
    // No PLL runs here, so pre-divider writes are always allowed
    wr(32'h2c, {1'b0, sel == 1, 13'h0, sel == 2, 8'h0, r, r});
    b1 = n1;
    b2 = n2;
    for (int i = 0; i < 6 * (r + 1); i++) begin
      src_tick <= (i % 2 == 0) ? (3'h4 >> sel) : 3'h0;
      second_prediv_in_tick <= (i % 2 == 0);
      @(posedge clk_sys);
    end
    src_tick <= 3'h0;
    second_prediv_in_tick <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(n1 - b1, 32'h3);
    chk(n2 - b2, 32'h3);
  endtask : t_div

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    {failures, n_tests, cyc, n1, n2} = '0;
    {rst, hsel, hwrite, companion_bit_write, companion_bit_wdata} = 5'h10;
    {haddr, hwdata, htrans, hsize, src_tick} = '0;
    second_prediv_in_tick = 1'b0;
    adc_psc_low_bits = 3'h5;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_fields();
    t_mult();
    t_dsv();
    t_comp();
    t_div(0, 4'h0);
    t_div(1, 4'h1);
    t_div(2, 4'hf);
    close_out();
  end
endmodule : pps_cfg_regs_test
